//--- timer_defines.svh
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH
// =====================================================
// register offsets
`define OFS_CC0_LOW   8'hda
`define OFS_CC0_HIGH  8'hdb
`define OFS_CTL_STAT  8'he4
`define OFS_CH0_CTL   8'he5
// =====================================================
// control and status field positions
`define BIT_CH2_FLAG  7
`define BIT_CH1_FLAG  6
`define BIT_CH0_FLAG  5
`define BIT_TC_FLAG   4
`define FLD_FLAGS     7:4
`define FLD_DIV       3:2
`define FLD_MODE      1:0
// =====================================================
// channel 0 control field positions
`define BIT_CAP_SRC   7
`define BIT_IRQ_MASK  6
`define FLD_ACT       5:3
`define BIT_CCMODE    2
`define FLD_EDGE      1:0
// =====================================================
// reset values and free-running top count
`define RST_CTL_STAT  8'h00
`define RST_CH0_CTL   8'h40
`define RST_CC0       16'h0000
`define CNT_TOP       16'hffff
// =====================================================
// prescaler last count for divide by 1, 8, 32, 128
`define DIV1_LAST     7'h00
`define DIV8_LAST     7'h07
`define DIV32_LAST    7'h1f
`define DIV128_LAST   7'h7f
`endif

//--- timer_pkg.sv
package timer_pkg;
    // =====================================================
    // counting modes
    typedef enum logic [1:0] {
        mode_suspend = 2'b00,
        mode_free    = 2'b01,
        mode_modulo  = 2'b10,
        mode_updown  = 2'b11
    } count_mode_t;

    // =====================================================
    // complete state of the timer core
    typedef struct packed {
        logic [15:0] cnt;
        logic        down;
        logic [15:0] cmp_act;
        logic [15:0] cmp_shadow;
        logic [7:0]  low_buf;
        logic        pend;
        logic [3:0]  flags;
        logic [1:0]  div;
        count_mode_t mode;
        logic [7:0]  ch0_ctl;
        logic        out;
        logic        irq;
        logic [7:0]  rdata;
    } timer_state_t;

    // =====================================================
    // input synchroniser state
    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
    } sync_state_t;
endpackage

//--- timer_prescaler.sv
`include "timer_defines.svh"
module timer_prescaler #(
    parameter int WIDTH = 7
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // control
    input  wire logic             tick,
    input  wire logic             run,
    input  wire logic [1:0]       div,
    // advance strobe
    output logic                  step
);
    logic [WIDTH-1:0] pcnt_r;
    logic [WIDTH-1:0] pcnt_nxt;
    logic [WIDTH-1:0] last;

    // divide code to last count
    always_comb begin
        unique case (div)
            2'b00: last = WIDTH'(`DIV1_LAST);
            2'b01: last = WIDTH'(`DIV8_LAST);
            2'b10: last = WIDTH'(`DIV32_LAST);
            2'b11: last = WIDTH'(`DIV128_LAST);
        endcase
    end

    // held at zero while suspended so restart gives a full period
    assign step = run & tick & (pcnt_r >= last);
    always_comb begin
        pcnt_nxt = pcnt_r;
        if (!run || step) begin
            pcnt_nxt = '0;
        end else if (tick) begin
            pcnt_nxt = pcnt_r + WIDTH'(1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pcnt_r <= '0;
        end else begin
            pcnt_r <= pcnt_nxt;
        end
    end

    step_tick_a: assert property (@(posedge clock) disable iff (rst)
        step |-> tick && run) else $error("advance without tick");
endmodule

//--- timer_edge_sync.sv
module timer_edge_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // pin and edges
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    timer_pkg::sync_state_t st_r;
    timer_pkg::sync_state_t st_nxt;

    // a change counts once stages two and three agree
    always_comb begin
        st_nxt = st_r;
        st_nxt.ff1 = pin;
        st_nxt.ff2 = st_r.ff1;
        st_nxt.ff3 = st_r.ff2;
        if (st_r.ff2 == st_r.ff3) begin
            st_nxt.level = st_r.ff3;
        end
    end

    assign rise = st_nxt.level & ~st_r.level;
    assign fall = ~st_nxt.level & st_r.level;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

//--- timer16_control_channel0.sv
// What this block does
// - channel 2, 1, 0 flags in bits 7, 6, 5 set on their events.
// - status flags clear only by writing zero; writing one leaves them.
// - overflow flag bit 4 sets at terminal count in free or modulo mode.
// - two-bit prescaler divides tick by 1, 8, 32 or 128.
// - mode 00 suspends counting.
// - mode 01 counts 0x0000 to 0xffff and wraps.
// - mode 10 counts 0x0000 to channel 0 compare value and restarts.
// - mode 11 counts up to compare value then down to zero.
// - bit 7 picks capture from pin (0) or radio event (1).
// - bit 6 mask, reset one, lets channel 0 events request interrupts.
// - on match, action 000 sets, 001 clears, 010 toggles output.
// - action 011 sets on up match, clears at zero outside up/down mode, at down match in it.
// - action 100 clears on up match, sets at zero outside up/down mode, at down match in it.
// - bit 2 selects capture (0) or compare (1) operation.
// - pin capture edge: 00 off, 01 rising, 10 falling, 11 both; radio events capture whatever the edge bits.
// - readable, writable high byte of compare value, resets to zero.
// - low byte write is buffered until the high byte is written.
// - actions 1 to 3 load compare at once; others at count zero.
// - setting the mask with flag already set requests an interrupt.
//
// Added by the designer: the plain strobed port.
`include "timer_defines.svh"
module timer16_control_channel0 (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // count sources and capture triggers
    input  wire logic        tick,
    input  wire logic        capture_pin,
    input  wire logic        radio_event,
    // events of channels 1 and 2
    input  wire logic        chan1_event,
    input  wire logic        chan2_event,
    // results
    output logic      [15:0] count_value,
    output logic      [3:0]  status_flags,
    output logic             chan0_out,
    output logic             chan0_irq
);
    timer_pkg::timer_state_t st_r;
    timer_pkg::timer_state_t st_nxt;
    logic       step;
    logic       pin_rise;
    logic       pin_fall;
    logic       run;
    logic       match;
    logic       at_zero;
    logic       cap_evt;
    logic       ch0_evt;
    logic       tc_evt;
    logic [2:0] act;
    logic [3:0] keep;

    // =====================================================
    // helpers

    // true for a write strobe at the given offset
    function automatic logic hit_wr(input logic [7:0] ofs);
        return wr && (addr == ofs);
    endfunction

    // =====================================================
    // count source and capture pin

    assign run = st_r.mode != timer_pkg::mode_suspend;

    timer_prescaler #(
        .WIDTH (7)
    ) u_prescaler (
        .clock (clock),
        .rst   (rst),
        .tick  (tick),
        .run   (run),
        .div   (st_r.div),
        .step  (step)
    );

    timer_edge_sync u_pin_sync (
        .clock (clock),
        .rst   (rst),
        .pin   (capture_pin),
        .rise  (pin_rise),
        .fall  (pin_fall)
    );

    // =====================================================
    // event decode

    assign act = st_r.ch0_ctl[`FLD_ACT];
    // matches only on an advance, so a suspended timer makes none
    assign match = step && st_r.ch0_ctl[`BIT_CCMODE]
                   && (st_r.cnt == st_r.cmp_act);
    assign at_zero = step && (st_r.cnt == 16'h0000);

    // capture trigger select and edge select
    always_comb begin
        cap_evt = 1'b0;
        if (!st_r.ch0_ctl[`BIT_CCMODE]) begin
            if (st_r.ch0_ctl[`BIT_CAP_SRC]) begin
                cap_evt = radio_event;
            end else begin
                cap_evt = (st_r.ch0_ctl[0] & pin_rise)
                        | (st_r.ch0_ctl[1] & pin_fall);
            end
        end
    end

    assign ch0_evt = match | cap_evt;

    // terminal count only in free-running and modulo
    always_comb begin
        tc_evt = 1'b0;
        if (step) begin
            if (st_r.mode == timer_pkg::mode_free) begin
                tc_evt = st_r.cnt == `CNT_TOP;
            end else if (st_r.mode == timer_pkg::mode_modulo) begin
                tc_evt = st_r.cnt >= st_r.cmp_act;
            end
        end
    end

    // zero bits written to the status flags clear them
    assign keep = hit_wr(`OFS_CTL_STAT) ? wdata[`FLD_FLAGS] : 4'hf;

    // =====================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.rdata = 8'h00;

        // counter
        if (step) begin
            unique case (st_r.mode)
                timer_pkg::mode_free: begin
                    st_nxt.cnt = st_r.cnt + 16'h0001;
                end
                timer_pkg::mode_modulo: begin
                    if (tc_evt) begin
                        st_nxt.cnt = 16'h0000;
                    end else begin
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                    end
                end
                timer_pkg::mode_updown: begin
                    // turns at the compare value and at zero
                    if (!st_r.down && st_r.cnt < st_r.cmp_act) begin
                        st_nxt.cnt = st_r.cnt + 16'h0001;
                    end else if (st_r.cnt != 16'h0000) begin
                        st_nxt.cnt = st_r.cnt - 16'h0001;
                        st_nxt.down = 1'b1;
                    end else begin
                        st_nxt.down = 1'b0;
                        if (st_r.cmp_act != 16'h0000) begin
                            st_nxt.cnt = 16'h0001;
                        end
                    end
                end
                timer_pkg::mode_suspend: begin
                    st_nxt.cnt = st_r.cnt;
                end
            endcase
        end
        if (st_r.mode != timer_pkg::mode_updown) begin
            st_nxt.down = 1'b0;
        end

        // compare output action
        if (st_r.ch0_ctl[`BIT_CCMODE]) begin
            unique case (act)
                3'b000: if (match) st_nxt.out = 1'b1;
                3'b001: if (match) st_nxt.out = 1'b0;
                3'b010: if (match) st_nxt.out = ~st_r.out;
                3'b011: begin
                    if (match && !st_r.down) begin
                        st_nxt.out = 1'b1;
                    end else if (st_r.mode == timer_pkg::mode_updown) begin
                        if (match) st_nxt.out = 1'b0;
                    end else if (at_zero) begin
                        st_nxt.out = 1'b0;
                    end
                end
                3'b100: begin
                    if (match && !st_r.down) begin
                        st_nxt.out = 1'b0;
                    end else if (st_r.mode == timer_pkg::mode_updown) begin
                        if (match) st_nxt.out = 1'b1;
                    end else if (at_zero) begin
                        st_nxt.out = 1'b1;
                    end
                end
                // codes above 100 are unused, output holds
                default: st_nxt.out = st_r.out;
            endcase
        end

        // status flags, a set in the clearing cycle wins
        st_nxt.flags = (st_r.flags & keep)
                     | {chan2_event, chan1_event, ch0_evt, tc_evt};

        // interrupt request, also when the mask is newly set
        if (hit_wr(`OFS_CH0_CTL)) begin
            st_nxt.ch0_ctl = wdata;
        end
        // flags are {ch2, ch1, ch0, terminal}, so channel 0 is bit 1
        st_nxt.irq = st_nxt.ch0_ctl[`BIT_IRQ_MASK]
                     & (ch0_evt | (~st_r.ch0_ctl[`BIT_IRQ_MASK]
                        & st_nxt.flags[1]));

        // control writes
        if (hit_wr(`OFS_CTL_STAT)) begin
            st_nxt.div = wdata[`FLD_DIV];
            st_nxt.mode = timer_pkg::count_mode_t'(wdata[`FLD_MODE]);
        end

        // deferred compare load when the count is at zero
        if (st_r.pend && st_r.cnt == 16'h0000) begin
            st_nxt.cmp_act = st_r.cmp_shadow;
            st_nxt.pend = 1'b0;
        end

        // compare value writes, low byte waits for the high byte
        if (hit_wr(`OFS_CC0_LOW)) begin
            st_nxt.low_buf = wdata;
        end
        if (hit_wr(`OFS_CC0_HIGH)) begin
            st_nxt.cmp_shadow = {wdata, st_r.low_buf};
            if (act >= 3'b001 && act <= 3'b011) begin
                st_nxt.cmp_act = {wdata, st_r.low_buf};
                st_nxt.pend = 1'b0;
            end else begin
                st_nxt.pend = 1'b1;
            end
        end

        // a capture overwrites both copies of the value
        if (cap_evt) begin
            st_nxt.cmp_shadow = st_r.cnt;
            st_nxt.cmp_act = st_r.cnt;
            st_nxt.pend = 1'b0;
        end

        // read data stand for the one cycle after the strobe
        if (rd) begin
            unique case (addr)
                `OFS_CC0_LOW:  st_nxt.rdata = st_r.cmp_shadow[7:0];
                `OFS_CC0_HIGH: st_nxt.rdata = st_r.cmp_shadow[15:8];
                `OFS_CTL_STAT: st_nxt.rdata = {st_r.flags, st_r.div,
                                               st_r.mode};
                `OFS_CH0_CTL:  st_nxt.rdata = st_r.ch0_ctl;
                default:       st_nxt.rdata = 8'h00;
            endcase
        end
    end

    // =====================================================
    // state register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= '{cnt: 16'h0000, down: 1'b0, cmp_act: `RST_CC0,
                      cmp_shadow: `RST_CC0, low_buf: 8'h00, pend: 1'b0,
                      flags: 4'h0, div: 2'b00,
                      mode: timer_pkg::mode_suspend,
                      ch0_ctl: `RST_CH0_CTL, out: 1'b0, irq: 1'b0,
                      rdata: 8'h00};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata = st_r.rdata;
    assign count_value = st_r.cnt;
    assign status_flags = st_r.flags;
    assign chan0_out = st_r.out;
    assign chan0_irq = st_r.irq;

    // =====================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    flag_set_a: assert property (chan1_event |=> status_flags[2])
        else $error("channel 1 flag not set");
    flag_clear_a: assert property (wr && addr == `OFS_CTL_STAT
        && !wdata[`BIT_CH2_FLAG] && !chan2_event |=> !status_flags[3])
        else $error("flag not cleared by zero");
    suspend_hold_a: assert property (st_r.mode == timer_pkg::mode_suspend
        |=> $stable(count_value) && !$rose(status_flags[0]))
        else $error("suspended timer moved");
    free_wrap_a: assert property (step && st_r.mode == timer_pkg::mode_free
        && count_value == 16'hffff |=> count_value == 16'h0000
        && status_flags[0]) else $error("free wrap wrong");
    modulo_wrap_a: assert property (step
        && st_r.mode == timer_pkg::mode_modulo
        && count_value == st_r.cmp_act |=> count_value == 16'h0000)
        else $error("modulo restart wrong");
    set_action_a: assert property (match && act == 3'b000
        |=> chan0_out) else $error("set action missed");
    high_load_a: assert property (wr && addr == `OFS_CC0_HIGH
        && act == 3'b001 && !cap_evt
        |=> st_r.cmp_act == {$past(wdata), $past(st_r.low_buf)})
        else $error("immediate compare load missed");
    mask_rise_a: assert property (wr && addr == `OFS_CH0_CTL
        && wdata[`BIT_IRQ_MASK] && !st_r.ch0_ctl[`BIT_IRQ_MASK]
        && status_flags[1]
        |=> chan0_irq) else $error("mask set gave no request");
    read_once_a: assert property (!rd |=> rdata == 8'h00)
        else $error("read data outside answer cycle");
endmodule

//--- timer16_control_channel0_tb.sv
`include "timer_defines.svh"
module timer16_control_channel0_tb;
    timeunit 1ns;
    timeprecision 1ps;

    // =====================================================
    // stimulus and observed signals
    logic        clock;
    logic        rst;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        tick;
    logic        capture_pin;
    logic        radio_event;
    logic        chan1_event;
    logic        chan2_event;
    logic [15:0] count_value;
    logic [3:0]  status_flags;
    logic        chan0_out;
    logic        chan0_irq;
    int          fail_count = 0;
    int          num_checks = 0;
    int          irq_count  = 0;

    // one register per row, written first when the flag is set, then read: address, data, write flag, read-back
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] d;
        logic       w;
        logic [7:0] e;
    } reg_row_t;
    reg_row_t reg_rows [12] = '{
        '{8'he4, 8'h00, 1'b0, 8'h00}, '{8'he5, 8'h00, 1'b0, 8'h40},
        '{8'hdb, 8'h00, 1'b0, 8'h00}, '{8'hda, 8'h00, 1'b0, 8'h00},
        '{8'h10, 8'h00, 1'b0, 8'h00}, '{8'he5, 8'ha5, 1'b1, 8'ha5},
        '{8'hdb, 8'h5a, 1'b1, 8'h5a}, '{8'he4, 8'h0c, 1'b1, 8'h0c},
        '{8'h10, 8'hff, 1'b1, 8'h00}, '{8'hda, 8'h33, 1'b1, 8'h00},
        '{8'hdb, 8'h5a, 1'b1, 8'h5a}, '{8'hda, 8'h00, 1'b0, 8'h33}
    };
    // output action rows: control value, output level after one period
    logic [8:0] act_rows [6] = '{{8'h4c, 1'b0}, {8'h54, 1'b1},
                                 {8'h54, 1'b0}, {8'h44, 1'b1},
                                 {8'h5c, 1'b0}, {8'h64, 1'b1}};
    int         div_rows [4] = '{1, 8, 32, 128};

    // =====================================================
    // design under test
    timer16_control_channel0 i_dut (
        .clock        (clock),
        .rst          (rst),
        .addr         (addr),
        .wdata        (wdata),
        .wr           (wr),
        .rd           (rd),
        .rdata        (rdata),
        .tick         (tick),
        .capture_pin  (capture_pin),
        .radio_event  (radio_event),
        .chan1_event  (chan1_event),
        .chan2_event  (chan2_event),
        .count_value  (count_value),
        .status_flags (status_flags),
        .chan0_out    (chan0_out),
        .chan0_irq    (chan0_irq)
    );

    // =====================================================
    // clock and interrupt pulse counter
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    always @(posedge clock) begin
        if (chan0_irq === 1'b1) begin
            irq_count++;
        end
    end

    // =====================================================
    // bus, tick and comparison tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe is taken
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic rd_cmp(output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd_reg(8'hda, lo);
        rd_reg(8'hdb, hi);
        v = {hi, lo};
    endtask

    // tick held high for n edges, then a few cycles for the step to land
    task automatic ticks(input int n);
        if (n > 0) begin
            @(posedge clock);
            tick <= 1'b1;
            repeat (n) @(posedge clock);
            tick <= 1'b0;
        end
        repeat (4) @(posedge clock);
        #1;
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // =====================================================
    // watchdog: the sequence needs about sixty-six thousand cycles
    initial begin
        #900us;
        fail_count++;
        end_of_test();
    end

    // =====================================================
    // main sequence
    initial begin
        logic [7:0]  r;
        logic [15:0] v;
        logic [15:0] c;
        logic        up;
        int          i0;
        {rst, addr, wdata, wr, rd, tick} = {1'b1, 8'h00, 8'h00, 3'b000};
        {capture_pin, radio_event, chan1_event, chan2_event} = 4'h0;
        do_reset();
        // register reset values, access kinds, low byte buffering
        foreach (reg_rows[k]) begin
            if (reg_rows[k].w) begin
                wr_reg(reg_rows[k].a, reg_rows[k].d);
            end
            rd_reg(reg_rows[k].a, r);
            check(16'(r), 16'(reg_rows[k].e));
        end
        // prescaler: one step after exactly div ticks, none after div-1
        do_reset();
        foreach (div_rows[k]) begin
            wr_reg(8'he4, 8'h00);
            wr_reg(8'he4, {4'h0, 2'(k), 2'b01});
            c = count_value;
            ticks(div_rows[k] - 1);
            check(count_value, c);
            ticks(1);
            check(count_value, c + 16'h0001);
        end
        // modulo 3 with set action: wrap, flags, output, interrupt
        do_reset();
        wr_reg(8'he5, 8'h44);
        wr_reg(8'hda, 8'h03);
        wr_reg(8'hdb, 8'h00);
        wr_reg(8'he4, 8'h02);
        ticks(5);
        check(count_value, 16'h0001);
        check(16'(status_flags), 16'h0003);
        check(16'(chan0_out), 16'h0001);
        check(16'(irq_count > 0), 16'h0001);
        rd_reg(8'he4, r);
        check(16'(r), 16'h0032);
        // zero clears a flag, one leaves it
        wr_reg(8'he4, 8'hd2);
        rd_reg(8'he4, r);
        check(16'(r), 16'h0012);
        foreach (act_rows[k]) begin
            wr_reg(8'he5, act_rows[k][8:1]);
            ticks(4);
            check(16'(chan0_out), 16'(act_rows[k][0]));
        end
        // masked event gives no request; unmasking a set flag gives one
        wr_reg(8'he5, 8'h0c);
        wr_reg(8'hdb, 8'h00);
        i0 = irq_count;
        ticks(4);
        check(16'(irq_count), 16'(i0));
        wr_reg(8'he5, 8'h4c);
        repeat (3) @(posedge clock);
        check(16'(irq_count), 16'(i0 + 1));
        @(posedge clock);
        {chan1_event, chan2_event} <= 2'b11;
        @(posedge clock);
        {chan1_event, chan2_event} <= 2'b00;
        repeat (2) @(posedge clock);
        check(16'(status_flags[3:2]), 16'h0003);
        // up/down between zero and 3, starting upward from 1
        wr_reg(8'he4, 8'h03);
        c  = 16'h0001;
        up = 1'b1;
        repeat (12) begin
            if (up && c == 16'h0003) up = 1'b0;
            if (!up && c == 16'h0000) up = 1'b1;
            c = up ? c + 16'h0001 : c - 16'h0001;
            ticks(1);
            check(count_value, c);
        end
        // capture from radio event, then from pin rising edge only
        do_reset();
        wr_reg(8'he4, 8'h01);
        ticks(5);
        check(count_value, 16'h0005);
        wr_reg(8'he4, 8'h00);
        ticks(10);
        check(count_value, 16'h0005);
        check(16'(status_flags), 16'h0000);
        wr_reg(8'he5, 8'hc3);
        @(posedge clock);
        radio_event <= 1'b1;
        @(posedge clock);
        radio_event <= 1'b0;
        rd_cmp(v);
        check(v, 16'h0005);
        check(16'(status_flags[1]), 16'h0001);
        wr_reg(8'he5, 8'h41);
        wr_reg(8'he4, 8'h01);
        ticks(3);
        wr_reg(8'he4, 8'h00);
        capture_pin <= 1'b1;
        repeat (8) @(posedge clock);
        rd_cmp(v);
        check(v, 16'h0008);
        wr_reg(8'he4, 8'h01);
        ticks(2);
        wr_reg(8'he4, 8'h00);
        capture_pin <= 1'b0;
        repeat (8) @(posedge clock);
        rd_cmp(v);
        check(v, 16'h0008);
        // falling edge only, then a free-running wrap past 0xffff
        wr_reg(8'he5, 8'h42);
        capture_pin <= 1'b1;
        repeat (8) @(posedge clock);
        capture_pin <= 1'b0;
        repeat (8) @(posedge clock);
        rd_cmp(v);
        check(v, 16'h000a);
        wr_reg(8'he4, 8'h01);
        ticks(65530);
        check(count_value, 16'h0004);
        check(16'(status_flags), 16'h0001);
        // asynchronous reset in mid-cycle returns everything to rest
        #3;
        rst = 1'b1;
        #1;
        check({count_value[11:0], status_flags}, 16'h0000);
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd_reg(8'he5, r);
        check(16'(r), 16'h0040);
        end_of_test();
    end
endmodule
